/* File: hdl/adcsq_top.v */
// Purpose: Sequencer and result registers of a 10-bit SAR converter.
// Assumes: All inputs synchronous to mclk; the converter answers within a conversion stage.
// Notes: Accumulator and filter arithmetic is a simple model; the threshold pulse logic is in this module too.
`timescale 1ns/1ns
`default_nettype none
`include "adcsq_defs.vh"

module adcsq_top (
    input wire mclk, // System clock, 100 MHz.
    input wire rst, // Synchronous reset, active high.
    input wire [4:0] addr, // Register address.
    input wire [7:0] wdata, // Write data.
    input wire wr, // Write strobe.
    input wire rd, // Read strobe.
    input wire [9:0] conv_data, // Converter result.
    input wire conv_done, // Converter finished a result.
    input wire trigger, // Conversion trigger pulse.
    output reg [7:0] rdata, // Read data, one cycle after rd.
    output reg [5:0] mux_sel, // Pin channel index to the analog multiplexer.
    output reg [3:0] mux_int, // One-hot internal source: ground, temp, DAC, reference.
    output reg mux_pin_en, // A pin channel is connected.
    output reg [4:0] cap_sel, // Extra sample capacitance in pF.
    output reg precharge_on, // Precharge stage active.
    output reg acquire_on, // Acquisition stage active.
    output reg conv_start, // Start pulse to the converter.
    output reg threshold_check, // Pulse at a result when counter reaches repeat threshold, in average, burst or low-pass mode only.
    output reg [2:0] stage_status // Stage code: 0 idle, 1-3 first, 5-7 second sample.
);

    parameter [5:0] PIN_LAST = 6'h22; // Highest pin code that is bonded.

    // ============================================================
    // Registers
    reg [5:0] positive_channel_select;
    reg [7:0] precharge_time;
    reg [7:0] acquisition_time;
    reg [4:0] extra_sample_cap;
    reg [7:0] repeat_threshold;
    reg [7:0] trigger_counter;
    reg [9:0] conversion_result;
    reg [7:0] result_high;
    reg [7:0] result_low;
    reg result_format_sel;
    reg conv_clock_source;
    reg double_sample_en;
    reg busy;
    reg [2:0] operating_mode_sel;
    reg [2:0] accum_shift_amount;
    reg accum_clear_cmd;
    reg [5:0] conv_clock_divider;
    reg [15:0] sample_accumulator;
    reg overflow_flag;
    reg [7:0] sample_count;
    reg [15:0] lowpass_state;
    reg [15:0] filter_output;
    reg [3:0] state;
    reg second;
    reg [8:0] stage_cnt;
    reg [6:0] div_cnt;
    reg adc_tick;
    // Latched copies so running stages see stable settings.
    reg [7:0] pre_lat;
    reg [7:0] acq_lat;
    reg cs_lat;
    reg [5:0] div_lat;

    // A cycle starts only from idle, so timing, clock, channel and capacitor writes made mid-cycle wait for the next one.
    wire start_cycle = busy && state == `ADCSQ_S_IDLE && !second;
    // The system clock path ignores the divider entirely.
    wire tick = cs_lat ? adc_tick : 1'b1;

    // Arithmetic shift used for both average outputs; truncates toward minus infinity.
    function [15:0] ashr;
        input [15:0] v;
        input [2:0] s;
        begin
            ashr = $signed(v) >>> s;
        end
    endfunction

    // Acquisition length from the latched codes, with the 256 case.
    function [8:0] acq_len;
        input [7:0] pre;
        input [7:0] acq;
        begin
            if (acq == `ADCSQ_ZERO8 && pre != `ADCSQ_ZERO8)
                acq_len = `ADCSQ_ACQ_DEFAULT;
            else
                acq_len = {1'b0, acq};
        end
    endfunction

    // ============================================================
    // Divided ADC clock: one tick every 2*(code+1) system clocks.
    // It free-runs, so a stage's first tick may come up to one period early.
    always @(posedge mclk) begin
        if (rst) begin
            div_cnt <= 7'h00;
            adc_tick <= 1'b0;
        end else if (div_cnt == {div_lat, 1'b1}) begin
            div_cnt <= 7'h00;
            adc_tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 7'h01;
            adc_tick <= 1'b0;
        end
    end

    // ============================================================
    // Register writes and hardware updates.
    always @(posedge mclk) begin
        if (rst) begin
            positive_channel_select <= 6'h00;
            precharge_time <= `ADCSQ_ZERO8;
            acquisition_time <= `ADCSQ_ZERO8;
            extra_sample_cap <= 5'h00;
            repeat_threshold <= `ADCSQ_ZERO8;
            result_format_sel <= 1'b0;
            conv_clock_source <= 1'b0;
            double_sample_en <= 1'b0;
            operating_mode_sel <= 3'h0;
            accum_shift_amount <= 3'h0;
            accum_clear_cmd <= 1'b0;
            conv_clock_divider <= 6'h00;
        end else begin
            if (wr) begin
                case (addr)
                    `ADCSQ_A_PCH: positive_channel_select <= wdata[5:0];
                    `ADCSQ_A_PRE: precharge_time <= wdata;
                    `ADCSQ_A_ACQ: acquisition_time <= wdata;
                    `ADCSQ_A_CAP: extra_sample_cap <= wdata[4:0];
                    `ADCSQ_A_RPT: repeat_threshold <= wdata;
                    `ADCSQ_A_CTRL: begin
                        result_format_sel <= wdata[`ADCSQ_CTRL_FRM];
                        conv_clock_source <= wdata[`ADCSQ_CTRL_CS];
                        double_sample_en <= wdata[`ADCSQ_CTRL_DSEN];
                    end
                    `ADCSQ_A_CTRL2: begin
                        operating_mode_sel <= wdata[2:0];
                        accum_shift_amount <= wdata[6:4];
                        accum_clear_cmd <= wdata[`ADCSQ_CTRL2_ACLR];
                    end
                    `ADCSQ_A_CLKDIV: conv_clock_divider <= wdata[5:0];
                    default: ;
                endcase
            end
            // The command bit drops once the clear below has taken effect.
            if (accum_clear_cmd && !(wr && addr == `ADCSQ_A_CTRL2))
                accum_clear_cmd <= 1'b0;
        end
    end

    // ============================================================
    // Trigger counter, result bytes and accumulator: not touched by reset.
    always @(posedge mclk) begin
        if (wr && addr == `ADCSQ_A_CNT)
            trigger_counter <= wdata;
        else if (trigger && trigger_counter != `ADCSQ_FF8)
            trigger_counter <= trigger_counter + `ADCSQ_ONE8;
        if (wr && addr == `ADCSQ_A_RESH)
            result_high <= wdata;
        else if (state == `ADCSQ_S_CONV && conv_done)
            result_high <= result_format_sel ? {6'h00, conv_data[9:8]} : conv_data[9:2];
        if (wr && addr == `ADCSQ_A_RESL)
            result_low <= wdata;
        else if (state == `ADCSQ_S_CONV && conv_done)
            result_low <= result_format_sel ? conv_data[7:0] : {conv_data[1:0], 6'h00};
        if (state == `ADCSQ_S_CONV && conv_done)
            conversion_result <= conv_data;
        // Clear wins over a sample landing in the same cycle; that sample is lost.
        if (accum_clear_cmd) begin
            sample_accumulator <= 16'h0000;
            overflow_flag <= 1'b0;
            sample_count <= `ADCSQ_ZERO8;
        end else if (state == `ADCSQ_S_CONV && conv_done) begin
            {overflow_flag, sample_accumulator} <=
                {overflow_flag, 16'h0000} | ({1'b0, sample_accumulator} + {7'h00, conv_data});
            if (sample_count != `ADCSQ_FF8)
                sample_count <= sample_count + `ADCSQ_ONE8;
            // First-order low-pass: y += (x - y) >> shift.
            lowpass_state <= lowpass_state +
                             ashr({6'h00, conv_data} - lowpass_state, accum_shift_amount);
        end
        if (rst)
            lowpass_state <= 16'h0000;
    end

    // ============================================================
    // Filter output follows the mode; software cannot write it.
    always @(posedge mclk) begin
        if (rst)
            filter_output <= 16'h0000;
        else if (operating_mode_sel == `ADCSQ_MD_LOWPASS)
            filter_output <= lowpass_state;
        // Other modes leave the last value standing rather than forcing zero.
        else if (operating_mode_sel == `ADCSQ_MD_ACC || operating_mode_sel == `ADCSQ_MD_AVG ||
                 operating_mode_sel == `ADCSQ_MD_BURST)
            filter_output <= ashr(sample_accumulator, accum_shift_amount);
    end

    // ============================================================
    // Stage sequencer: precharge, acquisition, conversion per sample.
    always @(posedge mclk) begin
        conv_start <= 1'b0;
        if (rst) begin
            state <= `ADCSQ_S_IDLE;
            busy <= 1'b0;
            second <= 1'b0;
            stage_cnt <= 9'h000;
            pre_lat <= `ADCSQ_ZERO8;
            acq_lat <= `ADCSQ_ZERO8;
            cs_lat <= 1'b0;
            div_lat <= 6'h00;
            mux_sel <= 6'h00;
            mux_int <= 4'h0;
            mux_pin_en <= 1'b0;
            cap_sel <= 5'h00;
        end else begin
            // Go and trigger only raise busy; a trigger while busy is absorbed.
            if (wr && addr == `ADCSQ_A_CTRL && wdata[`ADCSQ_CTRL_GO])
                busy <= 1'b1;
            else if (trigger)
                busy <= 1'b1;
            if (start_cycle) begin
                pre_lat <= precharge_time;
                acq_lat <= acquisition_time;
                cs_lat <= conv_clock_source;
                div_lat <= conv_clock_divider;
                cap_sel <= extra_sample_cap;
                mux_sel <= positive_channel_select;
                mux_pin_en <= positive_channel_select <= PIN_LAST;
                mux_int <= {positive_channel_select == `ADCSQ_CH_VREF,
                            positive_channel_select == `ADCSQ_CH_DAC,
                            positive_channel_select == `ADCSQ_CH_TEMP,
                            positive_channel_select == `ADCSQ_CH_AVSS};
            end
            case (state)
                `ADCSQ_S_IDLE: begin
                    if (start_cycle || second) begin
                        if ((start_cycle ? precharge_time : pre_lat) != `ADCSQ_ZERO8) begin
                            state <= `ADCSQ_S_PRE;
                            stage_cnt <= {1'b0, start_cycle ? precharge_time : pre_lat};
                        end else if (acq_len(start_cycle ? precharge_time : pre_lat,
                                             start_cycle ? acquisition_time : acq_lat) != 9'h000) begin
                            state <= `ADCSQ_S_ACQ;
                            stage_cnt <= acq_len(start_cycle ? precharge_time : pre_lat,
                                                 start_cycle ? acquisition_time : acq_lat);
                        end else begin
                            state <= `ADCSQ_S_CONV;
                            conv_start <= 1'b1;
                        end
                    end
                end
                `ADCSQ_S_PRE: begin
                    if (tick) begin
                        if (stage_cnt == `ADCSQ_ONE9) begin
                            if (acq_len(pre_lat, acq_lat) != 9'h000) begin
                                state <= `ADCSQ_S_ACQ;
                                stage_cnt <= acq_len(pre_lat, acq_lat);
                            end else begin
                                state <= `ADCSQ_S_CONV;
                                conv_start <= 1'b1;
                            end
                        end else
                            stage_cnt <= stage_cnt - `ADCSQ_ONE9;
                    end
                end
                `ADCSQ_S_ACQ: begin
                    if (tick) begin
                        if (stage_cnt == `ADCSQ_ONE9) begin
                            state <= `ADCSQ_S_CONV;
                            conv_start <= 1'b1;
                        end else
                            stage_cnt <= stage_cnt - `ADCSQ_ONE9;
                    end
                end
                `ADCSQ_S_CONV: begin
                    // The second sample reuses the settings latched for the first.
                    if (conv_done) begin
                        state <= `ADCSQ_S_IDLE;
                        if (double_sample_en && !second)
                            second <= 1'b1;
                        else begin
                            second <= 1'b0;
                            busy <= 1'b0;
                        end
                    end
                end
                default: state <= `ADCSQ_S_IDLE;
            endcase
        end
    end

    // ============================================================
    // Stage outputs and threshold pulse, all registered.
    // They trail the state by one clock, which the port contract allows for.
    always @(posedge mclk) begin
        if (rst) begin
            precharge_on <= 1'b0;
            acquire_on <= 1'b0;
            stage_status <= 3'h0;
            threshold_check <= 1'b0;
        end else begin
            precharge_on <= state == `ADCSQ_S_PRE;
            acquire_on <= state == `ADCSQ_S_ACQ;
            stage_status <= {second, state == `ADCSQ_S_CONV || state == `ADCSQ_S_ACQ,
                             state == `ADCSQ_S_CONV || state == `ADCSQ_S_PRE};
            threshold_check <= state == `ADCSQ_S_CONV && conv_done &&
                               (operating_mode_sel == `ADCSQ_MD_AVG ||
                                operating_mode_sel == `ADCSQ_MD_BURST ||
                                operating_mode_sel == `ADCSQ_MD_LOWPASS) &&
                               trigger_counter >= repeat_threshold;
        end
    end

    // ============================================================
    // Read port: data stand in the cycle after the strobe.
    // Unmapped offsets read zero, and so does the bus between reads.
    always @(posedge mclk) begin
        if (rst)
            rdata <= `ADCSQ_ZERO8;
        else if (rd) begin
            case (addr)
                `ADCSQ_A_PCH: rdata <= {2'b00, positive_channel_select};
                `ADCSQ_A_PRE: rdata <= precharge_time;
                `ADCSQ_A_ACQ: rdata <= acquisition_time;
                `ADCSQ_A_CAP: rdata <= {3'b000, extra_sample_cap};
                `ADCSQ_A_RPT: rdata <= repeat_threshold;
                `ADCSQ_A_CNT: rdata <= trigger_counter;
                `ADCSQ_A_FLTH: rdata <= filter_output[15:8];
                `ADCSQ_A_FLTL: rdata <= filter_output[7:0];
                `ADCSQ_A_RESH: rdata <= result_high;
                `ADCSQ_A_RESL: rdata <= result_low;
                `ADCSQ_A_CTRL: rdata <= {4'h0, double_sample_en, conv_clock_source,
                                         result_format_sel, busy};
                `ADCSQ_A_CTRL2: rdata <= {1'b0, accum_shift_amount, accum_clear_cmd,
                                          operating_mode_sel};
                `ADCSQ_A_CLKDIV: rdata <= {2'b00, conv_clock_divider};
                `ADCSQ_A_STAT: rdata <= {overflow_flag, 4'h0, stage_status};
                `ADCSQ_A_ACCH: rdata <= sample_accumulator[15:8];
                `ADCSQ_A_ACCL: rdata <= sample_accumulator[7:0];
                `ADCSQ_A_SCNT: rdata <= sample_count;
                `ADCSQ_A_RLOW: rdata <= conversion_result[7:0];
                default: rdata <= `ADCSQ_ZERO8;
            endcase
        end else
            rdata <= `ADCSQ_ZERO8;
    end

endmodule // adcsq_top

`default_nettype wire

/* File: hdl/adcsq_defs.vh */
// Purpose: Register offsets, field positions, reset values and state codes of the ADC sequencer.
// Assumes: Eight-bit register port, one word per offset.
// Notes: Offsets are local to this block.
`ifndef ADCSQ_DEFS_VH
`define ADCSQ_DEFS_VH

// ============================================================
// Register offsets
`define ADCSQ_A_PCH 5'h00
`define ADCSQ_A_PRE 5'h01
`define ADCSQ_A_ACQ 5'h02
`define ADCSQ_A_CAP 5'h03
`define ADCSQ_A_RPT 5'h04
`define ADCSQ_A_CNT 5'h05
`define ADCSQ_A_FLTH 5'h06
`define ADCSQ_A_FLTL 5'h07
`define ADCSQ_A_RESH 5'h08
`define ADCSQ_A_RESL 5'h09
`define ADCSQ_A_CTRL 5'h0a
`define ADCSQ_A_CTRL2 5'h0b
`define ADCSQ_A_CLKDIV 5'h0c
`define ADCSQ_A_STAT 5'h0d
`define ADCSQ_A_ACCH 5'h0e
`define ADCSQ_A_ACCL 5'h0f
`define ADCSQ_A_SCNT 5'h10
`define ADCSQ_A_RLOW 5'h11

// ============================================================
// Field positions and values
`define ADCSQ_CTRL_GO 0
`define ADCSQ_CTRL_FRM 1
`define ADCSQ_CTRL_CS 2
`define ADCSQ_CTRL_DSEN 3
`define ADCSQ_CTRL2_ACLR 3
`define ADCSQ_PCH_MASK 8'h3f
`define ADCSQ_CAP_MASK 8'h1f
`define ADCSQ_DIV_MASK 8'h3f
`define ADCSQ_ZERO8 8'h00
`define ADCSQ_FF8 8'hff
`define ADCSQ_ONE8 8'h01
`define ADCSQ_ONE9 9'h001
`define ADCSQ_ACQ_DEFAULT 9'h100
`define ADCSQ_CONV_CLKS 9'h00b
`define ADCSQ_CH_VREF 6'h3f
`define ADCSQ_CH_DAC 6'h3e
`define ADCSQ_CH_TEMP 6'h3d
`define ADCSQ_CH_AVSS 6'h3c
`define ADCSQ_MD_ACC 3'h1
`define ADCSQ_MD_AVG 3'h2
`define ADCSQ_MD_BURST 3'h3
`define ADCSQ_MD_LOWPASS 3'h4

// ============================================================
// Sequencer states, one-hot
`define ADCSQ_S_IDLE 4'h1
`define ADCSQ_S_PRE 4'h2
`define ADCSQ_S_ACQ 4'h4
`define ADCSQ_S_CONV 4'h8

`endif

/* File: test/adcsq_assertions.sv */
// Purpose: Port-level property checks for the ADC sequencer.
// Assumes: Timing registers are written only while the sequencer is idle.
// Notes: Shadow copies of timing registers are rebuilt from bus writes.
`timescale 1ns/1ns
`default_nettype none
`include "adcsq_defs.vh"
module adcsq_assertions #(parameter [5:0] PIN_LAST = 6'h22) (
    input wire logic mclk, // Clock.
    input wire logic rst, // Reset.
    input wire logic [4:0] addr, // Address.
    input wire logic [7:0] wdata, // Write data.
    input wire logic wr, // Write strobe.
    input wire logic rd, // Read strobe.
    input wire logic [7:0] rdata, // Read data.
    input wire logic [5:0] mux_sel, // Channel code.
    input wire logic [3:0] mux_int, // Internal source.
    input wire logic mux_pin_en, // Pin connected.
    input wire logic precharge_on, // Precharge level.
    input wire logic acquire_on, // Acquisition level.
    input wire logic conv_start, // Start pulse.
    input wire logic [2:0] stage_status // Stage code.
);
    logic [7:0] sh_pre;
    logic [7:0] sh_acq;
    logic sh_div;
    logic [8:0] pre_n;
    logic [8:0] acq_n;
    // ============================================================
    // Shadows and stage counters; durations are not visible on pins.
    always @(posedge mclk) begin
        if (rst) begin
            sh_pre <= 8'h00;
            sh_acq <= 8'h00;
            sh_div <= 1'b0;
            pre_n <= 9'h000;
            acq_n <= 9'h000;
        end else begin
            if (wr && addr == `ADCSQ_A_PRE) sh_pre <= wdata;
            if (wr && addr == `ADCSQ_A_ACQ) sh_acq <= wdata;
            if (wr && addr == `ADCSQ_A_CTRL) sh_div <= wdata[`ADCSQ_CTRL_CS];
            pre_n <= precharge_on ? pre_n + 9'h001 : 9'h000;
            acq_n <= acquire_on ? acq_n + 9'h001 : 9'h000;
        end
    end
    // ============================================================
    // Properties.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_pre_len;
        $fell(precharge_on) && !sh_div && !$past(rst) |-> pre_n == {1'b0, sh_pre};
    endproperty
    a_pre_len: assert property (p_pre_len) else $error("precharge length wrong");
    property p_pre_skip;
        sh_pre == 8'h00 |-> !$rose(precharge_on);
    endproperty
    a_pre_skip: assert property (p_pre_skip) else $error("precharge not skipped");
    property p_acq_len;
        $fell(acquire_on) && !sh_div && !$past(rst)
            |-> acq_n == ((sh_acq == 8'h00) ? 9'h100 : {1'b0, sh_acq});
    endproperty
    a_acq_len: assert property (p_acq_len) else $error("acquisition length wrong");
    property p_mux_map;
        stage_status != 3'h0 |-> mux_pin_en == (mux_sel <= PIN_LAST) && mux_int ==
            {mux_sel == 6'h3f, mux_sel == 6'h3e, mux_sel == 6'h3d, mux_sel == 6'h3c};
    endproperty
    a_mux_map: assert property (p_mux_map) else $error("channel routing wrong");
    property p_reserved;
        stage_status != 3'h0 && mux_sel > PIN_LAST && mux_sel < 6'h3c
            |-> !mux_pin_en && mux_int == 4'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code connects");
    property p_order;
        $changed(stage_status) && stage_status != 3'h0 |->
            stage_status[1:0] > $past(stage_status[1:0]) || $rose(stage_status[2]);
    endproperty
    a_order: assert property (p_order) else $error("stage order wrong");
    property p_start;
        conv_start |-> ##1 !conv_start && stage_status[1:0] == 2'h3;
    endproperty
    a_start: assert property (p_start) else $error("start pulse wrong");
    property p_masks;
        $past(rd) |-> !($past(addr) == `ADCSQ_A_PCH && rdata[7:6] != 2'h0)
            && !($past(addr) == `ADCSQ_A_CAP && rdata[7:5] != 3'h0);
    endproperty
    a_masks: assert property (p_masks) else $error("unused bits not zero");
    property p_reset;
        $fell(rst) |-> stage_status == 3'h0 && !precharge_on && !acquire_on && !conv_start;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not idle after reset");
endmodule // adcsq_assertions
bind adcsq_top adcsq_assertions #(.PIN_LAST(PIN_LAST)) i_adcsq_assertions (.mclk(mclk),
    .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .mux_sel(mux_sel), .mux_int(mux_int), .mux_pin_en(mux_pin_en),
    .precharge_on(precharge_on), .acquire_on(acquire_on), .conv_start(conv_start),
    .stage_status(stage_status));
`default_nettype wire

/* File: test/tb_top.sv */
// Purpose: Self-checking bench for the ADC sequencer.
// Assumes: The bench plays the converter and the register master.
// Notes: Stage durations are judged by the bound checker.
`timescale 1ns/1ns
`default_nettype none
`include "adcsq_defs.vh"
module tb_top;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] addr = 5'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [9:0] conv_data = 10'h000;
    logic conv_done = 1'b0;
    logic trigger = 1'b0;
    wire [7:0] rdata;
    wire [5:0] mux_sel;
    wire [3:0] mux_int;
    wire [4:0] cap_sel;
    wire [2:0] stage_status;
    wire mux_pin_en, precharge_on, acquire_on, conv_start, threshold_check;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    logic thr_seen = 1'b0;
    logic [3:0] m_int;
    logic m_pen;
    logic [4:0] m_cap;
    logic [5:0] codes [8] = '{6'h00, 6'h22, 6'h23, 6'h3b, 6'h3c, 6'h3d, 6'h3e, 6'h3f};
    adcsq_top #(.PIN_LAST(6'h22)) i_adcsq_top (.mclk(mclk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .conv_data(conv_data), .conv_done(conv_done),
        .trigger(trigger), .rdata(rdata), .mux_sel(mux_sel), .mux_int(mux_int),
        .mux_pin_en(mux_pin_en), .cap_sel(cap_sel), .precharge_on(precharge_on),
        .acquire_on(acquire_on), .conv_start(conv_start),
        .threshold_check(threshold_check), .stage_status(stage_status));
    // ============================================================
    // Clock, hang guard and threshold pulse catcher.
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (trigger) thr_seen <= 1'b0;
        else if (threshold_check === 1'b1) thr_seen <= 1'b1;
        if (cycles == 20000) begin
            err_count++;
            close_out();
        end
    end
    // ============================================================
    // Shared tasks.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rchk(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk({8'h00, rdata & m}, {8'h00, e});
    endtask
    task automatic run_conv(input logic [9:0] d);
        int i;
        @(posedge mclk);
        trigger <= 1'b1;
        @(posedge mclk);
        trigger <= 1'b0;
        for (i = 0; i < 700; i++) begin
            @(posedge mclk);
            #1;
            if (conv_start === 1'b1) break;
        end
        chk({15'h0000, conv_start}, 16'h0001);
        m_int = mux_int;
        m_pen = mux_pin_en;
        m_cap = cap_sel;
        @(posedge mclk);
        conv_data <= d;
        conv_done <= 1'b1;
        @(posedge mclk);
        conv_done <= 1'b0;
        conv_data <= ~d;
        for (i = 0; i < 700; i++) begin
            @(posedge mclk);
            #1;
            if (stage_status === 3'h0) break;
        end
        repeat (3) @(posedge mclk);
    endtask
    // ============================================================
    // Scenarios.
    task automatic t_regs;
        rchk(`ADCSQ_A_RPT, 8'hff, 8'h00);
        rchk(5'h1f, 8'hff, 8'h00);
        wreg(`ADCSQ_A_PCH, 8'hff);
        rchk(`ADCSQ_A_PCH, 8'hff, 8'h3f);
        wreg(`ADCSQ_A_CAP, 8'hff);
        rchk(`ADCSQ_A_CAP, 8'hff, 8'h1f);
    endtask
    task automatic t_channels;
        int k;
        logic [5:0] c;
        wreg(`ADCSQ_A_PRE, 8'h01);
        wreg(`ADCSQ_A_ACQ, 8'h01);
        for (k = 0; k < 8; k++) begin
            c = codes[k];
            wreg(`ADCSQ_A_PCH, {2'h0, c});
            wreg(`ADCSQ_A_CAP, {3'h0, c[4:0]});
            run_conv(10'h155);
            chk({10'h000, mux_sel}, {10'h000, c});
            chk({11'h000, m_pen, m_int}, {11'h000, c <= 6'h22, c == 6'h3f, c == 6'h3e,
                c == 6'h3d, c == 6'h3c});
            chk({11'h000, m_cap}, {11'h000, c[4:0]});
        end
    endtask
    task automatic t_timing;
        wreg(`ADCSQ_A_PRE, 8'h03);
        wreg(`ADCSQ_A_ACQ, 8'h00);
        run_conv(10'h001);
        wreg(`ADCSQ_A_PRE, 8'h00);
        wreg(`ADCSQ_A_ACQ, 8'hff);
        run_conv(10'h002);
    endtask
    task automatic t_result;
        run_conv(10'h2d7);
        rchk(`ADCSQ_A_RESH, 8'hff, 8'hb5);
        rchk(`ADCSQ_A_RESL, 8'hc0, 8'hc0);
        wreg(`ADCSQ_A_CTRL, 8'h02);
        run_conv(10'h2d7);
        rchk(`ADCSQ_A_RESH, 8'h03, 8'h02);
        rchk(`ADCSQ_A_RESL, 8'hff, 8'hd7);
        wreg(`ADCSQ_A_CTRL, 8'h00);
    endtask
    task automatic t_count;
        wreg(`ADCSQ_A_CNT, 8'hfe);
        run_conv(10'h010);
        run_conv(10'h011);
        rchk(`ADCSQ_A_CNT, 8'hff, 8'hff);
        wreg(`ADCSQ_A_CTRL2, 8'h02);
        wreg(`ADCSQ_A_RPT, 8'hff);
        wreg(`ADCSQ_A_CNT, 8'h00);
        run_conv(10'h012);
        chk({15'h0000, thr_seen}, 16'h0000);
        wreg(`ADCSQ_A_RPT, 8'h01);
        run_conv(10'h013);
        chk({15'h0000, thr_seen}, 16'h0001);
    endtask
    // Odd sample with a shift of one shows truncation in the filter output.
    task automatic t_filter;
        wreg(`ADCSQ_A_CTRL2, 8'h19);
        rchk(`ADCSQ_A_CTRL2, 8'h0f, 8'h01);
        run_conv(10'h2d7);
        rchk(`ADCSQ_A_FLTH, 8'hff, 8'h01);
        rchk(`ADCSQ_A_FLTL, 8'hff, 8'h6b);
        wreg(`ADCSQ_A_FLTL, 8'h00);
        rchk(`ADCSQ_A_FLTL, 8'hff, 8'h6b);
    endtask
    task automatic t_rereset;
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rchk(`ADCSQ_A_PCH, 8'hff, 8'h00);
        rchk(`ADCSQ_A_CNT, 8'hff, 8'h03);
    endtask
    // Double sampling in low-pass mode; run_conv returns with the second conversion open.
    task automatic t_double;
        wreg(`ADCSQ_A_CTRL2, 8'h04);
        wreg(`ADCSQ_A_CTRL, 8'h08);
        run_conv(10'h0aa);
        chk({13'h0000, stage_status}, 16'h0007);
        conv_data <= 10'h155;
        conv_done <= 1'b1;
        @(posedge mclk);
        conv_done <= 1'b0;
        repeat (2) @(posedge mclk);
        chk({13'h0000, stage_status}, 16'h0000);
        rchk(`ADCSQ_A_RESH, 8'hff, 8'h55);
        rchk(`ADCSQ_A_FLTL, 8'hff, 8'h55);
    endtask
    task automatic close_out;
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        t_regs();
        t_channels();
        t_timing();
        t_result();
        t_count();
        t_filter();
        t_rereset();
        t_double();
        close_out();
    end
endmodule // tb_top
`default_nettype wire
